// >>> inc/nvm_guard_regs.vh
// Notes on behaviour
// - six config words span 0x300000-0x30000B
// - implemented protection bits are one when blank
// - bit1 of code byte: zero guards data NVM
// - bit0 of code byte: zero guards program NVM
// - unimplemented bits read back as one
// - block bit zero blocks foreign table reads
// - boot byte: only bit 1 implemented
// - boot bit zero blocks foreign boot reads
`ifndef NVM_GUARD_REGS_VH
`define NVM_GUARD_REGS_VH

// ****************************************
// configuration space
// ****************************************
`define CFG_BASE_ADDR        24'h300000
`define CFG_LAST_ADDR        24'h30000B
`define CFG_WORD_COUNT       6
`define CFG_BYTE_COUNT       12

// ****************************************
// protection byte offsets
// ****************************************
`define CODE_PROTECT_LOW_OFS 24'h300008
`define BLOCK_RD_PROT_LOW_OFS 24'h30000A
`define BOOT_RD_PROT_HIGH_OFS 24'h30000B

// ****************************************
// field positions and masks
// ****************************************
`define DATA_GUARD_BIT       1
`define PROG_GUARD_BIT       0
`define BOOT_GUARD_BIT       1
`define CODE_PROTECT_IMPL    8'h03
`define BLOCK_RD_IMPL        8'hFF
`define BOOT_RD_IMPL         8'h02

// ****************************************
// blank value and blocked read value
// ****************************************
`define CFG_BLANK_BYTE       8'hFF
`define TBL_BLOCKED_DATA     8'h00

`endif

// >>> rtl/cfg_byte_store.v
`timescale 1ns/1ps
`default_nettype none
`include "nvm_guard_regs.vh"
// ****************************************
// twelve-byte configuration store, registered read
// ****************************************
module cfg_byte_store #(
    parameter DEPTH = 12,
    parameter AW    = 4
) (
    // clock and reset
    input  wire          clock_i,
    input  wire          sys_rst_i,
    // write port
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [7:0]    wr_data_i,
    input  wire [7:0]    wr_impl_i,
    // read port
    input  wire [AW-1:0] rd_addr_i,
    output reg  [7:0]    rd_data_o
);
    reg [7:0] mem_q [0:DEPTH-1];  // stored bytes
    integer   i;

    // blank device erases to ones; unimplemented bits forced to one
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= `CFG_BLANK_BYTE;
            rd_data_o <= `CFG_BLANK_BYTE;
        end else begin
            if (wr_en_i)
                mem_q[wr_addr_i] <= wr_data_i | ~wr_impl_i;
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule
`default_nettype wire

// >>> rtl/nvm_code_read_protection.v
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_guard_regs.vh"
// ****************************************
// nvm code and table read protection
// ****************************************
// holds the configuration bytes, reports the code protection bits and
// filters table reads against the block and boot read protection bits
module nvm_code_read_protection #(
    parameter BLOCKS = 8
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        sys_rst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [23:0] paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [3:0]  pstrb_i,
    output reg         pready_o,
    output reg  [31:0] prdata_o,
    output reg         pslverr_o,
    // table read request
    input  wire        tbl_req_i,
    input  wire [3:0]  tbl_target_blk_i,
    input  wire [3:0]  tbl_source_blk_i,
    input  wire        tbl_target_boot_i,
    input  wire        tbl_source_boot_i,
    input  wire [7:0]  tbl_mem_data_i,
    output reg         tbl_valid_o,
    output reg  [7:0]  tbl_data_o,
    output reg         tbl_blocked_o,
    // protection status
    output reg         data_nvm_guard_n_o,
    output reg         program_nvm_guard_n_o
);
    // ****************************************
    // decode
    // ****************************************
    // every byte address of the configuration space is its own register;
    // the low nibble of the address is the store index, anything outside
    // the space answers with a slave error and changes nothing
    localparam S_IDLE = 2'b00;  // waiting for access
    localparam S_READ = 2'b01;  // store read in flight
    localparam S_DONE = 2'b10;  // answer presented

    reg  [1:0] state_q;                     // apb sequencer
    reg  [7:0] block_table_read_guard_n_q;  // shadow of block byte, low bit = guarded
    reg        boot_table_read_guard_n_q;   // shadow of boot bit, low = guarded
    wire [7:0] store_rd;                    // store read data
    // the shadows mirror the stored bytes so the table filter never waits
    // for a store read; they are loaded by the same write strobe as the store

    // byte index inside configuration space, or out of range
    // index 16 marks an address outside the space
    function [4:0] cfg_index;
        input [23:0] a;
        begin
            if (a >= `CFG_BASE_ADDR && a <= `CFG_LAST_ADDR)
                cfg_index = {1'b0, a[3:0]};
            else
                cfg_index = 5'h10;
        end
    endfunction

    // implemented-bit mask per byte
    // bytes outside the protection set keep every bit writable
    function [7:0] impl_mask;
        input [23:0] a;
        begin
            case (a)
                `CODE_PROTECT_LOW_OFS:  impl_mask = `CODE_PROTECT_IMPL;
                `BLOCK_RD_PROT_LOW_OFS: impl_mask = `BLOCK_RD_IMPL;
                `BOOT_RD_PROT_HIGH_OFS: impl_mask = `BOOT_RD_IMPL;
                default:                impl_mask = 8'hFF;
            endcase
        end
    endfunction

    // address decode, held stable by the master for the whole transfer
    wire [4:0] idx    = cfg_index(paddr_i);  // byte index or out-of-range code
    wire       mapped = ~idx[4];             // address inside configuration space
    wire       access = psel_i & penable_i;  // access phase of a transfer
    // a write commits only at the edge that completes the transfer, when the
    // master samples pready high; an access phase that never ends stores nothing
    wire       wr_hit = access & pwrite_i & mapped & pstrb_i[0]
                        & (state_q == S_DONE) & pready_o;

    // ****************************************
    // configuration storage
    // ****************************************
    // one byte per address; byte lane 0 carries the data
    // unimplemented bits are forced to one on the way in
    // the read port follows the address every cycle
    cfg_byte_store #(
        .DEPTH (`CFG_BYTE_COUNT),
        .AW    (4)
    ) cfg_byte_store_inst (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .wr_en_i   (wr_hit),
        .wr_addr_i (idx[3:0]),
        .wr_data_i (pwdata_i[7:0]),
        .wr_impl_i (impl_mask(paddr_i)),
        .rd_addr_i (idx[3:0]),
        .rd_data_o (store_rd)
    );

    // ****************************************
    // apb sequencer: writes and unmapped accesses 1 wait, mapped reads 2 waits
    // ****************************************
    // write: access edge raises pready, completing edge stores the byte
    // read: access edge launches the store read, next edge loads prdata
    // pready and pslverr stand for exactly one cycle; prdata holds until the next access loads it
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q   <= S_IDLE;
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // take access
                    // writes and unmapped accesses need no store read
                    if (access && (pwrite_i || !mapped)) begin
                        pready_o  <= 1'b1;
                        pslverr_o <= ~mapped;
                        prdata_o  <= 32'h0000_0000;
                        state_q   <= S_DONE;
                    end else if (access) begin
                        state_q <= S_READ;
                    end
                end
                S_READ: begin
                    // store data now valid
                    // upper bytes of prdata read as zero
                    pready_o  <= 1'b1;
                    pslverr_o <= 1'b0;
                    prdata_o  <= {24'h000000, store_rd};
                    state_q   <= S_DONE;
                end
                S_DONE: begin
                    // end of access phase
                    // a write reaches the store and shadows at this edge
                    pready_o  <= 1'b0;
                    pslverr_o <= 1'b0;
                    state_q   <= S_IDLE;
                end
                default: begin
                    // unused code: return to idle
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // protection shadows, blank value is ones
    // ****************************************
    // the guard outputs only follow writes; reset restores the blank state
    // a write with lane 0 off leaves the shadows alone
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_nvm_guard_n_o         <= 1'b1;
            program_nvm_guard_n_o      <= 1'b1;
            block_table_read_guard_n_q <= `CFG_BLANK_BYTE;
            boot_table_read_guard_n_q  <= 1'b1;
        end else if (wr_hit) begin
            // update shadow on write of its byte
            if (paddr_i == `CODE_PROTECT_LOW_OFS) begin
                data_nvm_guard_n_o    <= pwdata_i[`DATA_GUARD_BIT];
                program_nvm_guard_n_o <= pwdata_i[`PROG_GUARD_BIT];
            end
            if (paddr_i == `BLOCK_RD_PROT_LOW_OFS)
                block_table_read_guard_n_q <= pwdata_i[7:0];
            if (paddr_i == `BOOT_RD_PROT_HIGH_OFS)
                boot_table_read_guard_n_q <= pwdata_i[`BOOT_GUARD_BIT];
        end
    end

    // ****************************************
    // table read filter
    // ****************************************
    reg tbl_block_d;  // this request is blocked
    // a read from inside its own block is never filtered
    // block numbers at or above BLOCKS are never guarded
    always @* begin
        tbl_block_d = 1'b0;
        if (tbl_target_boot_i) begin
            // boot block, guarded against any other block
            tbl_block_d = ~boot_table_read_guard_n_q & ~tbl_source_boot_i;
        end else if (tbl_target_blk_i < BLOCKS) begin
            tbl_block_d = ~block_table_read_guard_n_q[tbl_target_blk_i[2:0]]
                          & (tbl_source_boot_i
                             | (tbl_source_blk_i != tbl_target_blk_i));
        end
    end

    // answer one cycle after request; memory never written here
    // a blocked read still answers, with zero, so the requester never stalls
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tbl_valid_o   <= 1'b0;
            tbl_data_o    <= 8'h00;
            tbl_blocked_o <= 1'b0;
        end else begin
            tbl_valid_o   <= tbl_req_i;
            tbl_blocked_o <= tbl_req_i & tbl_block_d;
            if (tbl_req_i)
                tbl_data_o <= tbl_block_d ? `TBL_BLOCKED_DATA : tbl_mem_data_i;
        end
    end
endmodule
`default_nettype wire

// >>> tb/nvm_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// program memory contents seen by table reads
// ****************************************
module nvm_array_model (
    input  wire logic [3:0] blk_i,
    input  wire logic       boot_i,
    output logic      [7:0] data_o
);
    // never zero, so a suppressed byte cannot pass for real data
    assign data_o = boot_i ? 8'hB0 : {4'hC, blk_i};
endmodule
`default_nettype wire

// >>> tb/nvm_guard_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// register and table read checks
// ****************************************
module nvm_guard_props (
    input wire logic        clock_i, sys_rst_i, pwrite_i, pready_o, pslverr_o, tbl_req_i,
    input wire logic        tbl_target_boot_i, tbl_source_boot_i, tbl_valid_o, tbl_blocked_o,
    input wire logic        data_nvm_guard_n_o, program_nvm_guard_n_o,
    input wire logic [23:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic [3:0]  pstrb_i, tbl_target_blk_i, tbl_source_blk_i,
    input wire logic [7:0]  tbl_mem_data_i, tbl_data_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // address falls in the configuration space
    wire logic mapped = paddr_i >= 24'h300000 && paddr_i <= 24'h30000B;
    wire logic rd_end = pready_o && !pwrite_i;
    wire logic wr_code = pready_o && pwrite_i && paddr_i == 24'h300008 && pstrb_i[0];
    a_map_error: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("slave error wrong");
    a_code_ones: assert property (rd_end && paddr_i == 24'h300008
        |-> prdata_o[7:2] == 6'h3F)
        else $error("code byte upper bits");
    a_boot_ones: assert property (rd_end && paddr_i == 24'h30000B
        |-> (prdata_o[7:0] | 8'h02) == 8'hFF)
        else $error("boot byte spare bits");
    a_data_guard: assert property (wr_code
        |=> data_nvm_guard_n_o == $past(pwdata_i[1]))
        else $error("data guard");
    a_prog_guard: assert property (wr_code
        |=> program_nvm_guard_n_o == $past(pwdata_i[0]))
        else $error("program guard");
    a_blocked_zero: assert property (tbl_valid_o && tbl_blocked_o
        |-> tbl_data_o == 8'h00)
        else $error("blocked data");
    a_table_pass: assert property (tbl_req_i
        |=> tbl_valid_o && (tbl_blocked_o || tbl_data_o == $past(tbl_mem_data_i)))
        else $error("table answer");
    a_own_block: assert property (tbl_req_i && !tbl_target_boot_i && !tbl_source_boot_i
        && tbl_target_blk_i == tbl_source_blk_i |=> !tbl_blocked_o)
        else $error("own block blocked");
    a_boot_self: assert property (tbl_req_i && tbl_target_boot_i && tbl_source_boot_i
        |=> !tbl_blocked_o)
        else $error("boot self blocked");
endmodule
bind nvm_code_read_protection nvm_guard_props nvm_guard_props_inst (.clock_i, .sys_rst_i,
    .pwrite_i, .pready_o, .pslverr_o, .tbl_req_i, .tbl_target_boot_i, .tbl_source_boot_i,
    .tbl_valid_o, .tbl_blocked_o, .data_nvm_guard_n_o, .program_nvm_guard_n_o, .paddr_i,
    .pwdata_i, .prdata_o, .pstrb_i, .tbl_target_blk_i, .tbl_source_blk_i, .tbl_mem_data_i,
    .tbl_data_o);
`default_nettype wire

// >>> tb/nvm_code_read_protection_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_code_read_protection_bench;
    logic        clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic        tbl_req_i, tbl_target_boot_i, tbl_source_boot_i, tbl_valid_o, tbl_blocked_o;
    logic        data_nvm_guard_n_o, program_nvm_guard_n_o;
    logic [23:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0]  pstrb_i, tbl_target_blk_i, tbl_source_blk_i;
    logic [7:0]  tbl_mem_data_i, tbl_data_o;
    int          num_errors, tests_run, cycles;
    nvm_code_read_protection nvm_code_read_protection_inst (.clock_i, .sys_rst_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o,
        .tbl_req_i, .tbl_target_blk_i, .tbl_source_blk_i, .tbl_target_boot_i,
        .tbl_source_boot_i, .tbl_mem_data_i, .tbl_valid_o, .tbl_data_o, .tbl_blocked_o,
        .data_nvm_guard_n_o, .program_nvm_guard_n_o);
    nvm_array_model nvm_array_model_inst (.blk_i(tbl_target_blk_i), .boot_i(tbl_target_boot_i),
        .data_o(tbl_mem_data_i));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    task conclude;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %0t %s got %h", $time, m, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [23:0] a, input logic [7:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // one table read; partner data is 0xB0 for boot, 0xC0 plus block otherwise
    task tbl(input logic [3:0] t, s, input logic tb, sb, bl);
        @(posedge clock_i);
        tbl_req_i <= 1'b1;
        tbl_target_blk_i <= t;
        tbl_source_blk_i <= s;
        tbl_target_boot_i <= tb;
        tbl_source_boot_i <= sb;
        @(posedge clock_i);
        tbl_req_i <= 1'b0;
        @(negedge clock_i);
        chk({22'h0, tbl_valid_o, tbl_blocked_o, tbl_data_o},
            {22'h0, 1'b1, bl, bl ? 8'h00 : tb ? 8'hB0 : {4'hC, t}}, "table read");
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, tbl_req_i, tbl_target_boot_i, tbl_source_boot_i} = 6'h00;
        paddr_i = 24'h000000;
        pwdata_i = 32'h00000000;
        pstrb_i = 4'hF;
        tbl_target_blk_i = 4'h0;
        tbl_source_blk_i = 4'h0;
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, 24'h300000 + 24'(i), 8'h00);
            chk(rd, 32'h000000FF, "blank byte");
        end
        apb(1'b0, 24'h30000C, 8'h00);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped");
        apb(1'b1, 24'h300008, 8'h00);
        apb(1'b0, 24'h300008, 8'h00);
        chk(rd, 32'h000000FC, "code byte");
        apb(1'b1, 24'h300008, 8'h02);
        @(posedge clock_i);
        chk({data_nvm_guard_n_o, program_nvm_guard_n_o}, 32'h2, "guards");
        pstrb_i <= 4'h0;
        apb(1'b1, 24'h300008, 8'h01);
        pstrb_i <= 4'hF;
        apb(1'b0, 24'h300008, 8'h00);
        chk(rd, 32'h000000FE, "strobe off");
        chk({data_nvm_guard_n_o, program_nvm_guard_n_o}, 32'h2, "guards kept");
        apb(1'b1, 24'h30000A, 8'h5A);
        apb(1'b0, 24'h30000A, 8'h00);
        chk(rd, 32'h0000005A, "block byte");
        apb(1'b1, 24'h30000B, 8'h00);
        apb(1'b0, 24'h30000B, 8'h00);
        chk(rd, 32'h000000FD, "boot byte");
        for (int t = 0; t < 8; t++) begin
            tbl(4'(t), 4'((t + 1) % 8), 1'b0, 1'b0, ((8'h5A >> t) & 8'h01) == 8'h00);
            tbl(4'(t), 4'(t), 1'b0, 1'b0, 1'b0);
        end
        tbl(4'h0, 4'h0, 1'b0, 1'b1, 1'b1);
        tbl(4'h0, 4'h2, 1'b1, 1'b0, 1'b1);
        tbl(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
        apb(1'b1, 24'h30000B, 8'hFF);
        tbl(4'h0, 4'h3, 1'b1, 1'b0, 1'b0);
        // as programming tool the bench left every other word blank
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 24'h300000 + 24'(i), 8'h00);
            chk(rd, 32'h000000FF, "other word");
        end
        conclude();
    end
endmodule
`default_nettype wire
